// ===== design/block_list_checker.sv
// Block list parser and checker.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module block_list_checker #(
  parameter int LIST_DEPTH = 16
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Register port.
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Command byte stream.
  input wire logic i_cmd_start,
  input wire logic i_cmd_write,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  // Outcome reported by the tunnel host.
  input wire logic i_host_no_answer,
  input wire logic i_host_error,
  // Role query for one block index.
  input wire logic i_role_req,
  input wire logic [3:0] i_role_idx,
  output logic [1:0] o_role,
  // Per element results.
  output logic o_entry_valid,
  output logic [7:0] o_entry_num,
  output logic [11:0] o_entry_addr,
  output logic o_entry_access,
  // Command results.
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_status1,
  output logic [7:0] o_status2,
  output logic o_tunnel,
  output logic o_encrypted,
  output logic o_family_key
);
  localparam int AW = $clog2(LIST_DEPTH);

  // Parser states.
  typedef enum logic [2:0] {
    S_IDLE, S_SVC_K, S_SVC, S_BLK_M, S_ELEM
  } state_t;

  // Refuse a list memory too small or too big.
  initial begin
    if (LIST_DEPTH < block_list_checker_pkg::READ_MAX_BLK ||
        LIST_DEPTH > 16) begin
      $error("block_list_checker: LIST_DEPTH out of range");
    end
  end

  // Block limit for command kind and services.
  function automatic logic [7:0] blk_limit(input logic wr,
                                            input logic [7:0] k);
    if (!wr) begin
      blk_limit = 8'(block_list_checker_pkg::READ_MAX_BLK); // RQ7
    end else if (k <= 8'(block_list_checker_pkg::WRITE_FEW_SVC)) begin
      blk_limit = 8'(block_list_checker_pkg::WRITE_MAX_BLK_FEW); // RQ8
    end else begin
      blk_limit = 8'(block_list_checker_pkg::WRITE_MAX_BLK_MANY); // RQ8
    end
  endfunction

  // Role of block idx in a list of m blocks.
  function automatic logic [1:0] role_of(input logic enc,
                                         input logic [7:0] idx,
                                         input logic [7:0] m);
    if (!enc) begin
      role_of = block_list_checker_pkg::ROLE_PAYLOAD; // RQ15
    end else if (idx == 8'h00) begin
      role_of = block_list_checker_pkg::ROLE_IV; // RQ16
    end else if (idx == m - 8'h01) begin
      role_of = block_list_checker_pkg::ROLE_MAC; // RQ16
    end else if (idx >= m) begin
      role_of = block_list_checker_pkg::ROLE_DUMMY;
    end else begin
      role_of = block_list_checker_pkg::ROLE_PAYLOAD; // RQ16
    end
  endfunction

  // Reset synchroniser and its released copy.
  logic rst_meta_n;
  logic rst_n;
  // Parser state.
  state_t state;
  state_t next_state;
  // Command context.
  logic is_write;
  logic [7:0] svc_k;
  logic [7:0] svc_idx;
  logic [7:0] svc_hi;
  logic [15:0] svc_first;
  logic [7:0] blk_m;
  logic [7:0] elem_idx;
  logic [1:0] ebyte;
  logic [7:0] b0;
  logic [7:0] bnum;
  logic [7:0] prev_num;
  logic [2:0] first_mode;
  logic have_first;
  logic [7:0] acc_cnt;
  // First error seen, zero while none.
  logic [7:0] err;
  logic [7:0] next_err;
  // Software settings.
  logic [7:0] ro_first;
  logic ro_en;
  logic [7:0] enc_first;
  logic enc_en;
  logic [7:0] nvm_blocks;
  logic [AW-1:0] list_idx;
  logic [7:0] mem_rdata;
  // Element decode.
  logic elem_end;
  logic [7:0] third;
  logic [7:0] num_new;
  logic [2:0] mode_new;
  logic [2:0] mode_ref;
  logic access;
  logic last_elem;
  logic [7:0] elem_err;

  // Release reset through two flops, assert at once.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // Decode the element byte now arriving.
  always_comb begin
    elem_end = (state == S_ELEM) && i_byte_valid &&
               ((ebyte == 2'd1 && b0[block_list_checker_pkg::LEN_BIT])
                || ebyte == 2'd2);
    third = (ebyte == 2'd2) ? i_byte : 8'h00;
    num_new = (ebyte == 2'd1) ? i_byte : bnum;
    // A two byte element always means plaintext RF mode.
    mode_new = b0[block_list_checker_pkg::LEN_BIT] ? 3'b000
                                                   : third[2:0]; // RQ4
    mode_ref = have_first ? first_mode : mode_new;
    // Encrypted lists touch the first m-2 only.
    access = !mode_ref[block_list_checker_pkg::MODE_ENC_BIT] ||
             (elem_idx < blk_m - 8'(block_list_checker_pkg::
                                     ENC_PARAM_BLKS)); // RQ12 RQ10
    last_elem = (elem_idx == blk_m - 8'h01);
  end

  // Element checks; the first fault wins.
  always_comb begin
    elem_err = block_list_checker_pkg::ST_OK;
    if (b0[block_list_checker_pkg::ACC_HI:
           block_list_checker_pkg::ACC_LO] != 3'b000) begin
      elem_err = block_list_checker_pkg::ST_BLK_SPEC; // RQ2 RQ21
    end else if (third[block_list_checker_pkg::THIRD_ZERO_HI:
                       block_list_checker_pkg::THIRD_ZERO_LO] != 5'h00)
    begin
      elem_err = block_list_checker_pkg::ST_BLK_SPEC; // RQ3 RQ21
    end else if (mode_new[1:0] == 2'b01) begin
      elem_err = block_list_checker_pkg::ST_BLK_SPEC; // RQ6 RQ21
    end else if (mode_new != mode_ref) begin
      elem_err = block_list_checker_pkg::ST_BLK_SPEC; // RQ13
    end else if (mode_ref[block_list_checker_pkg::MODE_ENC_BIT] &&
                 blk_m <= 8'(block_list_checker_pkg::ENC_PARAM_BLKS))
    begin
      elem_err = block_list_checker_pkg::ST_BLK_RANGE; // RQ9 RQ19
    end else if (have_first && (mode_ref[2] || mode_ref[1]) &&
                 num_new != prev_num + 8'h01) begin
      elem_err = block_list_checker_pkg::ST_BLK_SPEC; // RQ11 RQ12 RQ14
    end else if (access && !mode_ref[2] && num_new >= nvm_blocks) begin
      elem_err = block_list_checker_pkg::ST_BLK_SPEC; // RQ21
    end else if (access && !mode_ref[2] && is_write && ro_en &&
                 num_new >= ro_first) begin
      elem_err = block_list_checker_pkg::ST_AREA; // RQ22
    end else if (access && !mode_ref[2] && !mode_ref[1] && enc_en &&
                 num_new >= enc_first) begin
      elem_err = block_list_checker_pkg::ST_AREA; // RQ22
    end
  end

  // Next parser state.
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        next_state = S_IDLE;
      end
      S_SVC_K: begin
        if (i_byte_valid) begin
          next_state = (next_err == block_list_checker_pkg::ST_OK) ?
                       S_SVC : S_IDLE;
        end
      end
      S_SVC: begin
        if (i_byte_valid && svc_idx == {svc_k[6:0], 1'b0} - 8'h01) begin
          next_state = S_BLK_M;
        end
      end
      S_BLK_M: begin
        if (i_byte_valid) begin
          next_state = (next_err == block_list_checker_pkg::ST_OK) ?
                       S_ELEM : S_IDLE;
        end
      end
      S_ELEM: begin
        if (elem_end && last_elem) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    if (i_cmd_start) begin
      next_state = S_SVC_K;
    end
  end

  // Next error: kept once set, until the next command start clears it.
  always_comb begin
    next_err = err; // RQ24
    if (i_cmd_start) begin
      next_err = block_list_checker_pkg::ST_OK;
    end else if (err == block_list_checker_pkg::ST_OK) begin
      if (state == S_SVC_K && i_byte_valid &&
          (i_byte == 8'h00 || i_byte > (i_cmd_write ?
           8'(block_list_checker_pkg::WRITE_MAX_SVC) :
           8'(block_list_checker_pkg::READ_MAX_SVC)))) begin
        next_err = block_list_checker_pkg::ST_SVC_RANGE; // RQ18 RQ23
      end else if (state == S_SVC && i_byte_valid && svc_idx[0] &&
                   svc_idx > 8'h01 && {svc_hi, i_byte} != svc_first)
      begin
        next_err = block_list_checker_pkg::ST_SVC_DIFF; // RQ20 RQ23
      end else if (state == S_BLK_M && i_byte_valid &&
                   (i_byte == 8'h00 ||
                    i_byte > blk_limit(is_write, svc_k))) begin
        next_err = block_list_checker_pkg::ST_BLK_RANGE; // RQ19
      end else if (elem_end) begin
        next_err = elem_err;
      end else if (state == S_IDLE && o_tunnel && i_host_no_answer) begin
        next_err = block_list_checker_pkg::ST_HOST_NONE; // RQ17
      end else if (state == S_IDLE && o_tunnel && i_host_error) begin
        next_err = block_list_checker_pkg::ST_HOST_ERR; // RQ17
      end
    end
  end

  // Parser state and error register.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      err <= block_list_checker_pkg::ST_OK;
    end else begin
      state <= next_state;
      err <= next_err;
    end
  end

  // Command context.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      is_write <= 1'b0;
      svc_k <= 8'h00;
      svc_idx <= 8'h00;
      svc_hi <= 8'h00;
      svc_first <= 16'h0000;
      blk_m <= 8'h00;
    end else if (i_cmd_start) begin
      is_write <= i_cmd_write;
      svc_idx <= 8'h00;
    end else if (i_byte_valid) begin
      if (state == S_SVC_K) begin
        svc_k <= i_byte;
      end
      // Service entries pair high byte then low byte.
      if (state == S_SVC) begin
        svc_idx <= svc_idx + 8'h01;
        if (!svc_idx[0]) begin
          svc_hi <= i_byte;
        end
        if (svc_idx == 8'h01) begin
          svc_first <= {svc_hi, i_byte};
        end
      end
      if (state == S_BLK_M) begin
        blk_m <= i_byte;
      end
    end
  end

  // Element byte tracking.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ebyte <= 2'd0;
      b0 <= 8'h00;
      bnum <= 8'h00;
      prev_num <= 8'h00;
      elem_idx <= 8'h00;
      first_mode <= 3'b000;
      have_first <= 1'b0;
      acc_cnt <= 8'h00;
    end else if (i_cmd_start) begin
      ebyte <= 2'd0;
      elem_idx <= 8'h00;
      have_first <= 1'b0;
      acc_cnt <= 8'h00;
    end else if (state == S_ELEM && i_byte_valid) begin
      if (elem_end) begin
        ebyte <= 2'd0;
        elem_idx <= elem_idx + 8'h01;
        prev_num <= num_new;
        have_first <= 1'b1;
        if (!have_first) begin
          first_mode <= mode_new;
        end
        if (access) begin
          acc_cnt <= acc_cnt + 8'h01;
        end
      end else begin
        ebyte <= ebyte + 2'd1;
        if (ebyte == 2'd0) begin
          b0 <= i_byte;
        end else begin
          bnum <= i_byte;
        end
      end
    end
  end

  // Per element result pulse.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_entry_valid <= 1'b0;
      o_entry_num <= 8'h00;
      o_entry_addr <= 12'h000;
      o_entry_access <= 1'b0;
    end else begin
      o_entry_valid <= elem_end;
      if (elem_end) begin
        o_entry_num <= num_new;
        o_entry_addr <= 12'({4'h0, num_new} *
                        block_list_checker_pkg::BLOCK_BYTES); // RQ1
        o_entry_access <= access; // RQ10 RQ12
      end
    end
  end

  // Command level results and status flags.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_status1 <= block_list_checker_pkg::ST_OK;
      o_status2 <= block_list_checker_pkg::ST_OK;
      o_tunnel <= 1'b0;
      o_encrypted <= 1'b0;
      o_family_key <= 1'b0;
    end else begin
      o_busy <= (next_state != S_IDLE);
      o_done <= (state != S_IDLE) && (next_state == S_IDLE);
      o_status2 <= next_err; // RQ24
      o_status1 <= (next_err == block_list_checker_pkg::ST_OK) ?
                   block_list_checker_pkg::ST_OK :
                   block_list_checker_pkg::ST_ERR; // RQ24
      if (i_cmd_start) begin
        o_tunnel <= 1'b0;
        o_encrypted <= 1'b0;
        o_family_key <= 1'b0;
      end else if (elem_end && !have_first) begin
        o_tunnel <= mode_new[block_list_checker_pkg::MODE_TUNNEL_BIT];
        o_encrypted <= mode_new[block_list_checker_pkg::MODE_ENC_BIT];
        o_family_key <= mode_new[block_list_checker_pkg::MODE_ENC_BIT] // RQ5
                        && mode_new[block_list_checker_pkg::MODE_KEY_BIT];
      end
    end
  end

  // Role answer, one cycle on.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_role <= block_list_checker_pkg::ROLE_PAYLOAD;
    end else if (i_role_req) begin
      o_role <= role_of(o_encrypted, {4'h0, i_role_idx}, blk_m);
    end
  end

  // Accessed block numbers, read by index.
  block_num_store #(
    .DEPTH(LIST_DEPTH),
    .WIDTH(8)
  ) u_store (
    .i_clk(i_clk),
    .i_we(elem_end && access),
    .i_waddr(elem_idx[AW-1:0]),
    .i_wdata(num_new),
    .i_raddr(list_idx),
    .o_rdata(mem_rdata)
  );

  // Software writes to settings.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ro_first <= block_list_checker_pkg::AREA_FIRST_RST;
      ro_en <= 1'b0;
      enc_first <= block_list_checker_pkg::AREA_FIRST_RST;
      enc_en <= 1'b0;
      nvm_blocks <= block_list_checker_pkg::NVM_BLOCKS_RST;
      list_idx <= '0;
    end else if (i_wr) begin
      case (i_addr)
        block_list_checker_pkg::ADDR_AREA: begin
          ro_first <= i_wdata[block_list_checker_pkg::AREA_RO_LO +: 8];
          ro_en <= i_wdata[block_list_checker_pkg::AREA_RO_EN_BIT];
          enc_first <= i_wdata[block_list_checker_pkg::AREA_ENC_LO +: 8];
          enc_en <= i_wdata[block_list_checker_pkg::AREA_ENC_EN_BIT];
        end
        block_list_checker_pkg::ADDR_NVM: begin
          nvm_blocks <= i_wdata[7:0];
        end
        block_list_checker_pkg::ADDR_LIST_IDX: begin
          list_idx <= i_wdata[AW-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Read data stand one cycle, else zero.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (!i_rd) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      case (i_addr)
        block_list_checker_pkg::ADDR_AREA: begin
          o_rdata <= {7'h00, enc_en, enc_first, 7'h00, ro_en, ro_first};
        end
        block_list_checker_pkg::ADDR_NVM: begin
          o_rdata <= {24'h000000, nvm_blocks};
        end
        block_list_checker_pkg::ADDR_STATUS: begin
          o_rdata <= {7'h00, o_busy, acc_cnt, o_status1, o_status2};
        end
        block_list_checker_pkg::ADDR_MODE: begin
          o_rdata <= {16'h0000, blk_m, 4'h0, is_write, first_mode};
        end
        block_list_checker_pkg::ADDR_LIST_IDX: begin
          o_rdata <= 32'(list_idx);
        end
        block_list_checker_pkg::ADDR_LIST_DATA: begin
          o_rdata <= {24'h000000, mem_rdata};
        end
        default: begin
          o_rdata <= 32'h0000_0000;
        end
      endcase
    end
  end
endmodule

// ===== design/block_num_store.sv
// Small memory of accessed block numbers.
`timescale 1ns/1ps
module block_num_store #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 8
) (
  // Clock.
  input wire logic i_clk,
  // Write port.
  input wire logic i_we,
  input wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  // Read port, data one cycle after the address.
  input wire logic [$clog2(DEPTH)-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);
  // Storage, not reset on purpose.
  logic [WIDTH-1:0] mem [DEPTH];

  // Refuse unusable shapes.
  initial begin
    if (DEPTH < 2 || WIDTH < 1) begin
      $error("block_num_store: bad DEPTH or WIDTH");
    end
  end

  // Store a number when asked.
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Registered read data.
  always_ff @(posedge i_clk) begin
    o_rdata <= mem[i_raddr];
  end
endmodule

// ===== include/block_list_checker_pkg.sv
// Shared constants and types.
// Notes on behaviour
// RQ1 - Blocks hold 16 data bytes.
// RQ2 - Access mode bits must be zero.
// RQ3 - Third byte bits 7:3 zero.
// RQ4 - Third byte bit 2 selects tunnel mode.
// RQ5 - Mode picks plaintext, private or family.
// RQ6 - Mode 01 reserved, rejected.
// RQ7 - Read allows at most fifteen blocks.
// RQ8 - Write allows 12 or 11 blocks.
// RQ9 - Encrypted lists spend two blocks on parameters.
// RQ10 - Plaintext RF lists accept any order.
// RQ11 - Plaintext tunnel lists must ascend.
// RQ12 - Encrypted: access first m-2, must ascend.
// RQ13 - All elements share one mode setting.
// RQ14 - Ascending order wraps from 0xff to 0x00.
// RQ15 - Plaintext blocks are all payload.
// RQ16 - Encrypted: IV first, MAC last, payload between.
// RQ17 - Tunnel host silence 0x50, host error 0x51.
// RQ18 - Bad service count reports 0xa1.
// RQ19 - Bad block count reports 0xa2.
// RQ20 - Differing service entries report 0xa3.
// RQ21 - Block specification faults report 0xa5.
// RQ22 - Area protection faults report 0x60.
// RQ23 - Read 15, write 11 services, all equal.
// RQ24 - Zero status on success, first error kept.
package block_list_checker_pkg;
  // Register byte addresses.
  localparam logic [7:0] ADDR_AREA = 8'h00;
  localparam logic [7:0] ADDR_NVM = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MODE = 8'h0c;
  localparam logic [7:0] ADDR_LIST_IDX = 8'h10;
  localparam logic [7:0] ADDR_LIST_DATA = 8'h14;
  // Field positions of the area register.
  localparam int AREA_RO_LO = 0;
  localparam int AREA_RO_EN_BIT = 8;
  localparam int AREA_ENC_LO = 16;
  localparam int AREA_ENC_EN_BIT = 24;
  // Reset values.
  localparam logic [7:0] AREA_FIRST_RST = 8'h00;
  localparam logic [7:0] NVM_BLOCKS_RST = 8'h20;
  // Element field positions.
  localparam int LEN_BIT = 7;
  localparam int ACC_HI = 6;
  localparam int ACC_LO = 4;
  localparam int THIRD_ZERO_HI = 7;
  localparam int THIRD_ZERO_LO = 3;
  localparam int MODE_TUNNEL_BIT = 2;
  localparam int MODE_ENC_BIT = 1;
  localparam int MODE_KEY_BIT = 0;
  // Status flag codes.
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_ERR = 8'hff;
  localparam logic [7:0] ST_HOST_NONE = 8'h50;
  localparam logic [7:0] ST_HOST_ERR = 8'h51;
  localparam logic [7:0] ST_SVC_RANGE = 8'ha1;
  localparam logic [7:0] ST_BLK_RANGE = 8'ha2;
  localparam logic [7:0] ST_SVC_DIFF = 8'ha3;
  localparam logic [7:0] ST_BLK_SPEC = 8'ha5;
  localparam logic [7:0] ST_AREA = 8'h60;
  // Count limits.
  localparam int BLOCK_BYTES = 16;
  localparam int READ_MAX_SVC = 15;
  localparam int WRITE_MAX_SVC = 11;
  localparam int READ_MAX_BLK = 15;
  localparam int WRITE_FEW_SVC = 8;
  localparam int WRITE_MAX_BLK_FEW = 12;
  localparam int WRITE_MAX_BLK_MANY = 11;
  localparam int ENC_PARAM_BLKS = 2;
  // Block role.
  typedef enum logic [1:0] {
    ROLE_PAYLOAD, ROLE_IV, ROLE_MAC, ROLE_DUMMY
  } role_t;
endpackage

// ===== testbench/block_list_checker_props.sv
// Port assertions.
`timescale 1ns/1ps
module block_list_checker_props (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Observed ports.
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_entry_valid,
  input wire logic [7:0] o_entry_num,
  input wire logic [11:0] o_entry_addr,
  input wire logic o_entry_access,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic [7:0] o_status1,
  input wire logic [7:0] o_status2,
  input wire logic o_tunnel,
  input wire logic o_encrypted,
  input wire logic o_family_key
);
  // One clock, one reset.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  status_pair_a: assert property (
    o_status2 != 8'h00 |-> o_status1 == 8'hff) else $error("bad pair");
  status_ok_a: assert property (
    o_status1 == 8'h00 |-> o_status2 == 8'h00) else $error("bad ok");
  entry_addr_a: assert property (
    o_entry_valid |-> o_entry_addr == {o_entry_num, 4'h0})
    else $error("bad addr");
  rdata_idle_a: assert property (
    !$past(i_rd) |-> o_rdata == 32'h0) else $error("rdata not idle");
  plain_access_a: assert property (
    o_entry_valid && !o_tunnel && !o_encrypted && o_status1 == 8'h00
    |-> o_entry_access) else $error("skipped");
  family_enc_a: assert property (
    o_family_key && o_status1 == 8'h00 |-> o_encrypted)
    else $error("family no enc");
  entry_pulse_a: assert property (
    o_entry_valid |=> !o_entry_valid) else $error("entry too long");
  busy_done_a: assert property (
    $fell(o_busy) |-> o_done) else $error("no done");
  done_gap_a: assert property (
    o_done |-> !o_busy ##1 !o_done) else $error("done wrong");
endmodule
bind block_list_checker block_list_checker_props
  block_list_checker_props_inst (.*);

// ===== testbench/block_list_checker_test.sv
// Self-checking bench.
`timescale 1ns/1ps
module block_list_checker_test;
  logic i_clk = 0, i_reset_n = 0, i_wr = 0, i_rd = 0, i_role_req = 0;
  logic i_host_no_answer = 0, i_host_error = 0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, area = 32'h0, r;
  logic [3:0] i_role_idx = 4'h0;
  logic i_cmd_start, i_cmd_write, i_byte_valid, o_entry_valid;
  logic [7:0] i_byte, o_entry_num, o_status1, o_status2, nums[$], d2s[$];
  logic [7:0] got[$], exp_q[$];
  logic [1:0] o_role;
  logic [11:0] o_entry_addr;
  logic o_entry_access, o_busy, o_done, o_tunnel, o_encrypted, o_family_key;
  int miscompares = 0, n_checks = 0, n_done, seed = 58;
  block_list_checker block_list_checker_inst (.*);
  rf_reader_model rdr (.i_clk(i_clk), .o_cmd_start(i_cmd_start),
    .o_cmd_write(i_cmd_write), .o_byte_valid(i_byte_valid), .o_byte(i_byte));
  // Free-running 100 MHz clock.
  always #5 i_clk = ~i_clk;
  // Collect results.
  always @(posedge i_clk) begin
    if (o_entry_valid === 1'b1 && o_entry_access === 1'b1)
      got.push_back(o_entry_num);
    if (o_done === 1'b1) n_done++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // Read data taken while it stands.
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rdata;
  endtask
  task automatic status_is(input logic [7:0] e);
    rd_reg(block_list_checker_pkg::ADDR_STATUS, r);
    check(r[15:0], {(e != 8'h00) ? 8'hff : 8'h00, e});
    check({o_status1, o_status2}, r[15:0]);
  endtask
  task automatic fill(input logic [7:0] s, input int n, input logic [7:0] d);
    for (int i = 0; i < n; i++) begin
      nums.push_back(s + 8'(i));
      d2s.push_back(d);
    end
  endtask
  // One command against the model.
  task automatic run(input logic wr, input int k, input bit sd,
                     input logic [7:0] d0, input int gap);
    int i, m, e, lim;
    logic th, tun, enc;
    th = !d0[7];
    m = nums.size();
    tun = th & d2s[0][2];
    enc = th & d2s[0][1];
    lim = wr ? (k <= 8 ? 12 : 11) : 15;
    e = 0;
    got = {};
    exp_q = {};
    rdr.q.push_back(8'(k));
    for (i = 0; i < k; i++) begin
      rdr.q.push_back(8'h09);
      rdr.q.push_back(8'(sd && i == 1));
    end
    rdr.q.push_back(8'(m));
    for (i = 0; i < m; i++) begin
      rdr.q.push_back(d0);
      rdr.q.push_back(nums[i]);
      if (th) rdr.q.push_back(d2s[i]);
    end
    if (k < 1 || k > (wr ? 11 : 15)) e = 'ha1;
    else if (sd) e = 'ha3;
    else if (m < 1 || m > lim) e = 'ha2;
    for (i = 0; i < m && e == 0; i++) begin
      if (d0[6:4] != 0 || th && (d2s[i][7:3] != 0 || d2s[i][1:0] == 1
          || d2s[i] != d2s[0])) e = 'ha5;
      else if (enc && m <= 2) e = 'ha2;
      else if ((tun || enc) && i > 0 && nums[i] != 8'(nums[i-1] + 1))
        e = 'ha5;
      else if (!tun && nums[i] >= 8'h20) e = 'ha5;
      else if (!tun && area[8] && wr && nums[i] >= area[7:0]) e = 'h60;
      else if (!tun && area[24] && !enc && nums[i] >= area[23:16]) e = 'h60;
      else if (!enc || i < m - 2) exp_q.push_back(nums[i]);
    end
    n_done = 0;
    rdr.send(wr, gap);
    for (i = 0; i < 20 && n_done == 0; i++) @(posedge i_clk);
    check(n_done, 1);
    status_is(8'(e));
    if (e == 0) begin
      check({o_tunnel, o_encrypted, o_family_key},
            {tun, enc, enc & d2s[0][0]});
      check(got.size(), exp_q.size());
      foreach (exp_q[j]) check(got[j], exp_q[j]);
    end
    nums = {};
    d2s = {};
  endtask
  task automatic host(input bit err, input logic [7:0] e);
    @(posedge i_clk);
    i_host_no_answer <= !err;
    i_host_error <= err;
    @(posedge i_clk);
    i_host_no_answer <= 1'b0;
    i_host_error <= 1'b0;
    status_is(e);
  endtask
  initial begin
    #500000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd_reg(block_list_checker_pkg::ADDR_NVM, r);
    check(r, 32'h20);
    rd_reg(8'h40, r);
    check(r, 32'h0);
    for (int j = 0; j < 15; j++) fill(8'($random(seed)) & 8'h1f, 1, 8'h00);
    run(0, 1, 0, 8'h80, $random(seed) & 1);
    fill(0, 16, 0); run(0, 1, 0, 8'h80, 0);
    fill(0, 12, 0); run(1, 8, 0, 8'h80, 0);
    fill(0, 12, 0); run(1, 9, 0, 8'h80, 0);
    fill(0, 11, 0); run(1, 11, 0, 8'h80, 1);
    for (int j = 0; j < 3; j++) begin
      fill(0, 1, 0);
      run(j == 2, (j == 0) ? 0 : 16 - 4 * (j / 2), 0, 8'h80, 0);
      fill(0, 1, 0);
      run(0, 1, 0, 8'h80 | (8'h10 << j), 0);
    end
    fill(0, 2, 0); run(0, 2, 1, 8'h80, 0);
    fill(3, 1, 8'h00); run(0, 1, 0, 8'h00, 0);
    fill(3, 1, 8'h08); run(0, 1, 0, 8'h00, 0);
    fill(3, 1, 8'h01); run(0, 1, 0, 8'h00, 0);
    fill(3, 1, 8'h05); run(0, 1, 0, 8'h00, 0);
    fill(8'hff, 4, 7); run(0, 1, 0, 8'h00, 1);
    for (int j = 0; j < 5; j++) begin
      @(posedge i_clk);
      i_role_req <= 1'b1;
      i_role_idx <= 4'(j);
      @(posedge i_clk);
      i_role_req <= 1'b0;
      @(negedge i_clk);
      check(o_role, (j == 0) ? 1 : (j < 3) ? 0 : (j == 3) ? 2 : 3);
    end
    fill(1, 4, 2); run(1, 1, 0, 8'h00, 0);
    fill(1, 2, 2); run(0, 1, 0, 8'h00, 0);
    fill(5, 1, 4); fill(7, 1, 4); run(0, 1, 0, 8'h00, 0);
    fill(5, 3, 4); run(0, 1, 0, 8'h00, 2);
    host(0, 8'h50);
    fill(5, 3, 6); run(0, 1, 0, 8'h00, 0);
    host(1, 8'h51);
    fill(1, 2, 2); fill(3, 1, 6); run(0, 1, 0, 8'h00, 0);
    fill(8'h20, 1, 0); run(0, 1, 0, 8'h80, 0);
    area = 32'h0000_0110;
    wr_reg(block_list_checker_pkg::ADDR_AREA, area);
    fill(8'h12, 1, 0); run(1, 1, 0, 8'h80, 0);
    fill(8'h0f, 1, 0); run(1, 1, 0, 8'h80, 0);
    area = 32'h0110_0000;
    wr_reg(block_list_checker_pkg::ADDR_AREA, area);
    rd_reg(block_list_checker_pkg::ADDR_AREA, r);
    check(r, area);
    fill(8'h12, 1, 0); run(0, 1, 0, 8'h80, 0);
    fill(8'h12, 4, 2); run(0, 1, 0, 8'h00, 0);
    tally_and_finish();
  end
endmodule

// ===== testbench/rf_reader_model.sv
// Reader model streaming command bytes.
`timescale 1ns/1ps
module rf_reader_model (
  // Clock.
  input wire logic i_clk,
  // Command stream.
  output logic o_cmd_start,
  output logic o_cmd_write,
  output logic o_byte_valid,
  output logic [7:0] o_byte
);
  // Queued bytes.
  logic [7:0] q[$];
  initial begin
    o_cmd_start = 1'b0;
    o_cmd_write = 1'b0;
    o_byte_valid = 1'b0;
    o_byte = 8'h00;
  end
  // Start, then bytes with gap idle cycles.
  task automatic send(input logic wr, input int gap);
    @(posedge i_clk);
    o_cmd_start <= 1'b1;
    o_cmd_write <= wr;
    while (q.size() > 0) begin
      @(posedge i_clk);
      o_cmd_start <= 1'b0;
      o_byte_valid <= 1'b1;
      o_byte <= q.pop_front();
      repeat (gap) begin
        @(posedge i_clk);
        o_byte_valid <= 1'b0;
        // Toggle idle data.
        o_byte <= ~o_byte;
      end
    end
    @(posedge i_clk);
    o_cmd_start <= 1'b0;
    o_byte_valid <= 1'b0;
  endtask
endmodule
